// [hdl/adc_regs_pkg.sv]
// constants, field layouts and carriers of the converter register bank
// assumes one system clock; the serial command engine drives the access port
package adc_regs_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 16;

  // register offsets
  localparam logic [3:0] OFS_GAIN_BURNOUT_CONFIG  = 4'h0;
  localparam logic [3:0] OFS_INPUT_CHANNEL_SELECT = 4'h1;
  localparam logic [3:0] OFS_ANALOG_CONTROL       = 4'h2;
  localparam logic [3:0] OFS_OFFSET_DAC_SETTING   = 4'h3;
  localparam logic [3:0] OFS_IO_PIN_DATA          = 4'h4;
  localparam logic [3:0] OFS_IO_PIN_DIRECTION     = 4'h5;
  localparam logic [3:0] OFS_IO_PIN_FUNCTION      = 4'h6;
  localparam logic [3:0] OFS_OFFSET_CAL_LOW       = 4'h7;
  localparam logic [3:0] OFS_OFFSET_CAL_MID       = 4'h8;
  localparam logic [3:0] OFS_OFFSET_CAL_HIGH      = 4'h9;
  localparam logic [3:0] OFS_GAIN_CAL_LOW         = 4'ha;
  localparam logic [3:0] OFS_GAIN_CAL_MID         = 4'hb;
  localparam logic [3:0] OFS_GAIN_CAL_HIGH        = 4'hc;
  localparam logic [3:0] OFS_RESULT_HIGH          = 4'hd;
  localparam logic [3:0] OFS_RESULT_MID           = 4'he;
  localparam logic [3:0] OFS_RESULT_LOW           = 4'hf;

  // reset values
  localparam logic [7:0] RST_INPUT_CHANNEL_SELECT = 8'h01;
  localparam logic [7:0] RST_ANALOG_CONTROL       = 8'h00;
  localparam logic [7:0] RST_ZERO                 = 8'h00;
  localparam logic [7:0] RST_IO_PIN_DIRECTION     = 8'hff;
  localparam logic [7:0] RST_GAIN_CAL_LOW         = 8'h59;
  localparam logic [7:0] RST_GAIN_CAL_MID         = 8'h55;
  localparam logic [7:0] RST_GAIN_CAL_HIGH        = 8'h55;
  localparam logic [3:0] RST_GAIN_SETUP_LOW       = 4'h0;
  localparam logic [3:0] CHAN_CODE_MAX            = 4'h7;

  // identification nibble, value arbitrary
  localparam logic [3:0] DEVICE_ID_DEFAULT = 4'h5;

  // writable analog control fields, bit 7 excluded
  typedef struct packed {
    logic       unipolar;
    logic       slow_modulator;
    logic       input_buffer_on;
    logic       output_bit_order;
    logic       half_range;
    logic [1:0] output_rate_select;
  } analog_control_t;

  typedef struct packed {
    logic [3:0] positive_input_select;
    logic [3:0] negative_input_select;
  } channel_select_t;

  typedef struct packed {
    logic       negative;
    logic [6:0] offset_magnitude;
  } offset_dac_t;

  // settings applied to the analog front end
  typedef struct packed {
    logic            burnout_source_enable;
    logic [2:0]      gain_select;
    channel_select_t chan;
    analog_control_t analog_control;
    offset_dac_t     offset_dac_setting;
    logic [23:0]     offset_cal;
    logic [23:0]     gain_cal;
  } front_end_cfg_t;

  // register access from the serial command engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // updates from the calibration engine and converter
  typedef struct packed {
    logic        offset_cal_load;
    logic [23:0] offset_cal;
    logic        gain_cal_load;
    logic [23:0] gain_cal;
    logic        result_load;
    logic [23:0] result;
  } core_update_t;

endpackage

// [hdl/adc_config_register_bank.sv]
// configuration and result register bank of a 24-bit delta-sigma converter
// assumes the serial command engine and converter core share i_clk_sys;
// the shared i/o pins and result-ready level arrive from outside and are synchronised
module adc_config_register_bank
#(
  parameter logic [3:0] DEVICE_ID = adc_regs_pkg::DEVICE_ID_DEFAULT,
  parameter int unsigned NUM_PINS = 8
) (
  // clock, reset, enable
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_rst,
  input  wire logic                         i_clk_en,
  // register access
  input  wire adc_regs_pkg::reg_req_t       i_req,
  output logic [7:0]                        o_rdata,
  output logic                              o_rvalid,
  // converter and calibration updates
  input  wire adc_regs_pkg::core_update_t   i_core,
  // result-ready pin level, active low
  input  wire logic                         i_result_ready_n,
  // shared data pins
  input  wire logic [NUM_PINS-1:0]          i_pin,
  output logic [NUM_PINS-1:0]               o_pin,
  output logic [NUM_PINS-1:0]               o_pin_oe,
  // front end settings
  output adc_regs_pkg::front_end_cfg_t      o_cfg
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic                          burnout_source_enable;
    logic [2:0]                    gain_select;
    adc_regs_pkg::channel_select_t chan;
    adc_regs_pkg::analog_control_t analog_control;
    adc_regs_pkg::offset_dac_t     offset_dac_setting;
    logic [7:0]                    io_pin_data;
    logic [7:0]                    io_pin_direction;
    logic [7:0]                    io_pin_function;
    logic [23:0]                   offset_cal;
    logic [23:0]                   gain_cal;
    logic [23:0]                   result;
    logic [1:0]                    rdy_sync;
    logic [NUM_PINS-1:0]           pin_meta;
    logic [NUM_PINS-1:0]           pin_sync;
    logic [7:0]                    rdata;
    logic                          rvalid;
    logic [NUM_PINS-1:0]           pin_out;
    logic [NUM_PINS-1:0]           pin_oe;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [7:0] pins_in_byte;
  logic [7:0] pin_readback;
  logic       rdy_level;

  ////////////////////////////////////////////////////////////////////////////
  // read-only views
  always_comb begin
    pins_in_byte = '0;
    pins_in_byte[NUM_PINS-1:0] = s_q.pin_sync;
    // digital output pins read back what is driven, digital inputs read the pin, analog pins read the data byte
    pin_readback = (s_q.io_pin_function & ~s_q.io_pin_direction & s_q.io_pin_data)
                 | (s_q.io_pin_function & s_q.io_pin_direction & pins_in_byte)
                 | (~s_q.io_pin_function & s_q.io_pin_data);
    rdy_level = s_q.rdy_sync[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    // two-stage synchronisers; the first stage feeds only the second
    s_d.rdy_sync = {s_q.rdy_sync[0], i_result_ready_n};
    s_d.pin_meta = i_pin;
    s_d.pin_sync = s_q.pin_meta;
    s_d.rvalid = 1'b0;

    // core loads first so a host write in the same cycle wins afterwards
    if (i_core.offset_cal_load) begin
      s_d.offset_cal = i_core.offset_cal;
    end
    if (i_core.gain_cal_load) begin
      s_d.gain_cal = i_core.gain_cal;
    end
    if (i_core.result_load) begin
      s_d.result = i_core.result;
    end

    if (i_req.wr) begin
      if (i_req.addr == adc_regs_pkg::OFS_GAIN_BURNOUT_CONFIG) begin
        // id nibble is not stored, so writes cannot touch it
        s_d.burnout_source_enable = i_req.wdata[3];
        s_d.gain_select = i_req.wdata[2:0];
      end else if (i_req.addr == adc_regs_pkg::OFS_INPUT_CHANNEL_SELECT) begin
        s_d.chan = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL) begin
        s_d.analog_control = i_req.wdata[6:0];
      end else if (i_req.addr == adc_regs_pkg::OFS_OFFSET_DAC_SETTING) begin
        s_d.offset_dac_setting = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_IO_PIN_DATA) begin
        s_d.io_pin_data = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_IO_PIN_DIRECTION) begin
        s_d.io_pin_direction = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_IO_PIN_FUNCTION) begin
        s_d.io_pin_function = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_OFFSET_CAL_LOW) begin
        s_d.offset_cal[7:0] = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_OFFSET_CAL_MID) begin
        s_d.offset_cal[15:8] = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_OFFSET_CAL_HIGH) begin
        s_d.offset_cal[23:16] = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_GAIN_CAL_LOW) begin
        s_d.gain_cal[7:0] = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_GAIN_CAL_MID) begin
        s_d.gain_cal[15:8] = i_req.wdata;
      end else if (i_req.addr == adc_regs_pkg::OFS_GAIN_CAL_HIGH) begin
        s_d.gain_cal[23:16] = i_req.wdata;
      end
      // result bytes have no write path
    end

    if (i_req.rd) begin
      s_d.rvalid = 1'b1;
      if (i_req.addr == adc_regs_pkg::OFS_GAIN_BURNOUT_CONFIG) begin
        s_d.rdata = {DEVICE_ID, s_q.burnout_source_enable, s_q.gain_select};
      end else if (i_req.addr == adc_regs_pkg::OFS_INPUT_CHANNEL_SELECT) begin
        s_d.rdata = s_q.chan;
      end else if (i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL) begin
        s_d.rdata = {rdy_level, s_q.analog_control};
      end else if (i_req.addr == adc_regs_pkg::OFS_OFFSET_DAC_SETTING) begin
        s_d.rdata = s_q.offset_dac_setting;
      end else if (i_req.addr == adc_regs_pkg::OFS_IO_PIN_DATA) begin
        s_d.rdata = pin_readback;
      end else if (i_req.addr == adc_regs_pkg::OFS_IO_PIN_DIRECTION) begin
        s_d.rdata = s_q.io_pin_direction;
      end else if (i_req.addr == adc_regs_pkg::OFS_IO_PIN_FUNCTION) begin
        s_d.rdata = s_q.io_pin_function;
      end else if (i_req.addr == adc_regs_pkg::OFS_OFFSET_CAL_LOW) begin
        s_d.rdata = s_q.offset_cal[7:0];
      end else if (i_req.addr == adc_regs_pkg::OFS_OFFSET_CAL_MID) begin
        s_d.rdata = s_q.offset_cal[15:8];
      end else if (i_req.addr == adc_regs_pkg::OFS_OFFSET_CAL_HIGH) begin
        s_d.rdata = s_q.offset_cal[23:16];
      end else if (i_req.addr == adc_regs_pkg::OFS_GAIN_CAL_LOW) begin
        s_d.rdata = s_q.gain_cal[7:0];
      end else if (i_req.addr == adc_regs_pkg::OFS_GAIN_CAL_MID) begin
        s_d.rdata = s_q.gain_cal[15:8];
      end else if (i_req.addr == adc_regs_pkg::OFS_GAIN_CAL_HIGH) begin
        s_d.rdata = s_q.gain_cal[23:16];
      end else if (i_req.addr == adc_regs_pkg::OFS_RESULT_HIGH) begin
        s_d.rdata = s_q.result[23:16];
      end else if (i_req.addr == adc_regs_pkg::OFS_RESULT_MID) begin
        s_d.rdata = s_q.result[15:8];
      end else begin
        s_d.rdata = s_q.result[7:0];
      end
    end

    // pins driven only when digital and direction is output
    s_d.pin_oe = s_d.io_pin_function[NUM_PINS-1:0]
               & ~s_d.io_pin_direction[NUM_PINS-1:0];
    s_d.pin_out = s_d.io_pin_data[NUM_PINS-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_q.burnout_source_enable <= 1'b0;
      s_q.gain_select           <= adc_regs_pkg::RST_GAIN_SETUP_LOW[2:0];
      s_q.chan                  <= adc_regs_pkg::RST_INPUT_CHANNEL_SELECT;
      s_q.analog_control                   <= adc_regs_pkg::RST_ANALOG_CONTROL[6:0];
      s_q.offset_dac_setting                  <= adc_regs_pkg::RST_ZERO;
      s_q.io_pin_data           <= adc_regs_pkg::RST_ZERO;
      s_q.io_pin_direction      <= adc_regs_pkg::RST_IO_PIN_DIRECTION;
      s_q.io_pin_function       <= adc_regs_pkg::RST_ZERO;
      s_q.offset_cal            <= {3{adc_regs_pkg::RST_ZERO}};
      s_q.gain_cal              <= {adc_regs_pkg::RST_GAIN_CAL_HIGH,
                                    adc_regs_pkg::RST_GAIN_CAL_MID,
                                    adc_regs_pkg::RST_GAIN_CAL_LOW};
      s_q.result                <= {3{adc_regs_pkg::RST_ZERO}};
      s_q.rdy_sync              <= 2'h3;
      s_q.pin_meta              <= '0;
      s_q.pin_sync              <= '0;
      s_q.rdata                 <= adc_regs_pkg::RST_ZERO;
      s_q.rvalid                <= 1'b0;
      s_q.pin_out               <= '0;
      s_q.pin_oe                <= '0;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    o_rdata  = s_q.rdata;
    o_rvalid = s_q.rvalid;
    o_pin    = s_q.pin_out;
    o_pin_oe = s_q.pin_oe;
    o_cfg.burnout_source_enable = s_q.burnout_source_enable;
    o_cfg.gain_select           = s_q.gain_select;
    o_cfg.chan                  = s_q.chan;
    o_cfg.analog_control                   = s_q.analog_control;
    o_cfg.offset_dac_setting                  = s_q.offset_dac_setting;
    o_cfg.offset_cal            = s_q.offset_cal;
    o_cfg.gain_cal              = s_q.gain_cal;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_ID_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.rd && i_req.addr == adc_regs_pkg::OFS_GAIN_BURNOUT_CONFIG
    |=> o_rvalid && o_rdata[7:4] == DEVICE_ID)
    else $error("id nibble wrong on read");

  AST_BURNOUT_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_GAIN_BURNOUT_CONFIG
    |=> o_cfg.burnout_source_enable == $past(i_req.wdata[3])
        && o_cfg.gain_select == $past(i_req.wdata[2:0]))
    else $error("gain setup write not applied");

  // looked at on the release edge: before the first reset edge the state is unknown
  AST_CHAN_RESET: assert property (@(posedge i_clk_sys)
    $fell(i_rst) |-> o_cfg.chan == adc_regs_pkg::RST_INPUT_CHANNEL_SELECT)
    else $error("channel select reset value wrong");

  AST_ACR_RESET: assert property (@(posedge i_clk_sys)
    $fell(i_rst) |-> o_cfg.analog_control == adc_regs_pkg::RST_ANALOG_CONTROL[6:0])
    else $error("analog control reset value wrong");

  AST_READY_MIRROR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.rd && i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL
    |=> o_rdata == {$past(rdy_level), $past(s_q.analog_control)})
    else $error("ready mirror bit wrong");

  AST_DIR_RESET: assert property (@(posedge i_clk_sys)
    $fell(i_rst) |-> o_pin_oe == '0)
    else $error("pins driven after reset");

  AST_PIN_DRIVE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_pin_oe == (s_q.io_pin_function[NUM_PINS-1:0] & ~s_q.io_pin_direction[NUM_PINS-1:0]))
    else $error("pin enable disagrees with function and direction");

  AST_RESULT_RO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr >= adc_regs_pkg::OFS_RESULT_HIGH
    && !i_core.result_load |=> $stable(s_q.result))
    else $error("result changed by host write");

  AST_RESULT_ORDER: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.rd && i_req.addr == adc_regs_pkg::OFS_RESULT_HIGH
    |=> o_rdata == $past(s_q.result[23:16]))
    else $error("result high byte wrong");

  AST_OFFSET_LOW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_OFFSET_CAL_LOW
    |=> o_cfg.offset_cal[7:0] == $past(i_req.wdata))
    else $error("offset low byte not written");

  AST_RVALID_PULSE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en |=> o_rvalid == $past(i_req.rd))
    else $error("read valid is not a one-cycle answer");

  AST_POS_SELECT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_INPUT_CHANNEL_SELECT
    |=> o_cfg.chan.positive_input_select == $past(i_req.wdata[7:4]))
    else $error("positive input select not written");

  AST_NEG_SELECT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_INPUT_CHANNEL_SELECT
    |=> o_cfg.chan.negative_input_select == $past(i_req.wdata[3:0]))
    else $error("negative input select not written");

  AST_CODING_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL
    |=> o_cfg.analog_control.unipolar == $past(i_req.wdata[6]))
    else $error("output coding bit not written");

  AST_SPEED_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL
    |=> o_cfg.analog_control.slow_modulator == $past(i_req.wdata[5]))
    else $error("modulator speed bit not written");

  AST_BUFFER_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL
    |=> o_cfg.analog_control.input_buffer_on == $past(i_req.wdata[4]))
    else $error("input buffer bit not written");

  AST_ORDER_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL
    |=> o_cfg.analog_control.output_bit_order == $past(i_req.wdata[3]))
    else $error("bit order not written");

  AST_RANGE_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL
    |=> o_cfg.analog_control.half_range == $past(i_req.wdata[2]))
    else $error("range bit not written");

  AST_RATE_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_ANALOG_CONTROL
    |=> o_cfg.analog_control.output_rate_select == $past(i_req.wdata[1:0]))
    else $error("output rate not written");

  AST_OFFSET_DAC_SETTING_MAGNITUDE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_OFFSET_DAC_SETTING
    |=> o_cfg.offset_dac_setting.offset_magnitude == $past(i_req.wdata[6:0]))
    else $error("offset dac magnitude not written");

  AST_OFFSET_DAC_SETTING_SIGN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_OFFSET_DAC_SETTING
    |=> o_cfg.offset_dac_setting.negative == $past(i_req.wdata[7]))
    else $error("offset dac sign not written");

  AST_GAIN_HIGH: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.wr && i_req.addr == adc_regs_pkg::OFS_GAIN_CAL_HIGH
    |=> o_cfg.gain_cal[23:16] == $past(i_req.wdata))
    else $error("gain high byte not written");

  AST_RESULT_LOW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_clk_en && i_req.rd && i_req.addr == adc_regs_pkg::OFS_RESULT_LOW
    |=> o_rdata == $past(s_q.result[7:0]))
    else $error("result low byte wrong");

endmodule

// [test/converter_model.sv]
// stand-in for the converter core and calibration engine beside the bank
// assumes the bench calls its tasks between clock edges of i_clk
module converter_model (
  // clock
  input  wire logic                  i_clk,
  // toward the register bank
  output adc_regs_pkg::core_update_t o_core,
  output logic                       o_result_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_core = '0;
    o_result_ready_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stale words are inverted once the load strobe drops, so nothing leans on them
  task automatic load_result(input logic [23:0] d);
    @(posedge i_clk);
    o_core.result_load <= 1'b1;
    o_core.result      <= d;
    o_result_ready_n   <= 1'b0;
    @(posedge i_clk);
    o_core.result_load <= 1'b0;
    o_core.result      <= ~d;
  endtask

  task automatic load_offset(input logic [23:0] d);
    @(posedge i_clk);
    o_core.offset_cal_load <= 1'b1;
    o_core.offset_cal      <= d;
    @(posedge i_clk);
    o_core.offset_cal_load <= 1'b0;
    o_core.offset_cal      <= ~d;
  endtask
endmodule

// [test/adc_config_register_bank_tb.sv]
// self-checking bench for the converter register bank
// assumes converter_model drives the core side; bench drives requests and pins
module adc_config_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0] ID = 4'ha;  // arbitrary identification value

  logic                         clk;
  logic                         rst;
  logic                         clk_en;
  adc_regs_pkg::reg_req_t       req;
  adc_regs_pkg::core_update_t   core;
  logic                         rdy_n;
  logic [7:0]                   pin_in;
  logic [7:0]                   pin_out;
  logic [7:0]                   pin_oe;
  logic [7:0]                   rdata;
  logic                         rvalid;
  adc_regs_pkg::front_end_cfg_t cfg;
  int                           n_errors;
  int                           num_checks;
  int                           cycles;
  logic [7:0]                   rst_tab [16];

  ////////////////////////////////////////////////////////////////////////////
  adc_config_register_bank #(.DEVICE_ID(ID), .NUM_PINS(8)) adc_config_register_bank_i (
    .i_clk_sys(clk), .i_rst(rst), .i_clk_en(clk_en), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_core(core), .i_result_ready_n(rdy_n), .i_pin(pin_in),
    .o_pin(pin_out), .o_pin_oe(pin_oe), .o_cfg(cfg));

  converter_model converter_model_i (.i_clk(clk), .o_core(core), .o_result_ready_n(rdy_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard, well above the roughly 150 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    // step past the taking edge so callers see the updated settings
    #1;
  endtask

  // answer lands on the same edge that takes the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(24'(rvalid), 24'h000001);
    chk(24'(rdata), 24'(e));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_tab = '{{ID, 4'h0}, 8'h01, 8'h80, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
                8'h00, 8'h00, 8'h59, 8'h55, 8'h55, 8'h00, 8'h00, 8'h00};
    clk_en = 1'b1;
    rst    = 1'b1;
    req    = '0;
    pin_in = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;

    for (int a = 0; a < 16; a++) rd_chk(a[3:0], rst_tab[a]);
    chk(24'(pin_oe), 24'h000000);
    $display("reset values done");

    for (int a = 1; a < 13; a++) begin
      if (a != 2 && a != 4) begin
        wr(a[3:0], 8'h3c ^ a[7:0]);
        rd_chk(a[3:0], 8'h3c ^ a[7:0]);
      end
    end
    chk(24'(cfg.chan), 24'h00003d);
    chk(24'(cfg.offset_dac_setting), 24'h00003f);
    chk(cfg.offset_cal, 24'h35343b);
    chk(cfg.gain_cal, 24'h303736);
    wr(4'h3, 8'h85);
    chk(24'(cfg.offset_dac_setting.negative), 24'h000001);
    $display("read write done");

    wr(4'h0, 8'hff);
    rd_chk(4'h0, {ID, 4'hf});
    chk(24'(cfg.burnout_source_enable), 24'h000001);
    chk(24'(cfg.gain_select), 24'h000007);
    wr(4'h2, 8'hff);
    chk(24'(cfg.analog_control), 24'h00007f);
    $display("setup fields done");

    converter_model_i.load_result(24'hc3a5f1);
    for (int a = 13; a < 16; a++) wr(a[3:0], 8'h00);
    wr(4'h2, 8'hd5);
    rd_chk(4'h2, 8'h55);
    rd_chk(4'hd, 8'hc3);
    rd_chk(4'he, 8'ha5);
    rd_chk(4'hf, 8'hf1);
    converter_model_i.load_offset(24'h123456);
    rd_chk(4'h7, 8'h56);
    rd_chk(4'h9, 8'h12);
    chk(cfg.offset_cal, 24'h123456);
    $display("core loads done");

    wr(4'h6, 8'hff);
    wr(4'h5, 8'h0f);
    wr(4'h4, 8'ha5);
    @(posedge clk);
    pin_in <= 8'h3c;
    repeat (4) @(posedge clk);
    chk(24'(pin_oe), 24'h0000f0);
    chk(24'(pin_out & pin_oe), 24'h0000a0);
    rd_chk(4'h4, 8'hac);
    $display("pins done");

    @(posedge clk);
    clk_en <= 1'b0;
    wr(4'h1, 8'h77);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(4'h1, 8'h3d);
    $display("clock enable done");

    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h1, 8'h01);
    rd_chk(4'h0, {ID, 4'h0});
    chk(24'(pin_oe), 24'h000000);
    chk(cfg.gain_cal, 24'h555559);
    chk(cfg.offset_cal, 24'h000000);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule
